// [rtl/stepper_defines.svh]
// Shared constants for the full-step sequencer.
// Assumes inclusion by bare name from files under rtl/.
`ifndef STEPPER_DEFINES_SVH
`define STEPPER_DEFINES_SVH

`define CODE_FULL 4'hF
`define CODE_ZERO 4'h0
`define CODE_W 4
`define RATE_W 16
`define RATE_RESET 16'h0000

`endif

// [rtl/stepper_pkg.sv]
// Types for the full-step sequencer.
// Assumes the defines header is available on the include path.
package stepper_pkg;

    // Electrical position within one four-step cycle
    typedef enum logic [1:0] {
        POS_0,
        POS_1,
        POS_2,
        POS_3
    } pos_t;

    typedef enum logic {
        MODE_WAVE,
        MODE_TWO
    } mode_t;

    function automatic pos_t pos_next(input pos_t p);
        unique case (p)
            POS_0: pos_next = POS_1;
            POS_1: pos_next = POS_2;
            POS_2: pos_next = POS_3;
            POS_3: pos_next = POS_0;
        endcase
    endfunction

    function automatic pos_t pos_prev(input pos_t p);
        unique case (p)
            POS_0: pos_prev = POS_3;
            POS_1: pos_prev = POS_0;
            POS_2: pos_prev = POS_1;
            POS_3: pos_prev = POS_2;
        endcase
    endfunction

endpackage

// [rtl/rate_if.sv]
// Carrier between the sequencer and its step-rate divider.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`include "stepper_defines.svh"

interface rate_if;
    logic run;
    logic [`RATE_W-1:0] period;
    logic tick;

    modport gen (input run, input period, output tick);
    modport user (output run, output period, input tick);
endinterface

// [rtl/step_rate_gen.sv]
// Step-rate divider: one-cycle tick every 'period' clocks while running.
// Assumes period is held steady by the user while run is high.
`timescale 1ns/1ps
`include "stepper_defines.svh"

module step_rate_gen (
    input wire logic clk_sys,
    input wire logic rst_n,
    rate_if.gen rif
);
    logic [`RATE_W-1:0] cnt_q, cnt_d;
    logic tick_q, tick_d;

    always_comb begin
        cnt_d = cnt_q;
        tick_d = 1'b0;
        // A zero period means stopped, not a tick every cycle
        if (!rif.run || rif.period == `RATE_RESET) begin
            cnt_d = `RATE_RESET;
        end else if (cnt_q >= rif.period - 16'h0001) begin
            cnt_d = `RATE_RESET;
            tick_d = 1'b1;
        end else begin
            cnt_d = cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= `RATE_RESET;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign rif.tick = tick_q;

    a_tick_period: assert property (@(posedge clk_sys) disable iff (!rst_n)
        tick_q |-> cnt_q == `RATE_RESET)
        else $error("tick without counter restart");
endmodule

// [rtl/full_step_sequencer.sv]
// Full-step sequencer driving two bridge channels (direction, brake, code).
// Assumes commands come from logic on clk_sys; the bridges protect
// themselves and need no help from this side.
`timescale 1ns/1ps
`include "stepper_defines.svh"

module full_step_sequencer
    import stepper_pkg::*;
#(
    parameter int CODE_BITS = `CODE_W,
    parameter int RATE_BITS = `RATE_W
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic mode_two,
    input wire logic step_req,
    input wire logic dir_fwd,
    input wire logic auto_run,
    input wire logic [RATE_BITS-1:0] rate_period,
    output logic dir_a,
    output logic brake_a,
    output logic [CODE_BITS-1:0] code_a,
    output logic dir_b,
    output logic brake_b,
    output logic [CODE_BITS-1:0] code_b,
    output logic step_done
);
    rate_if rif ();

    // Code table and rate carrier are fixed width; refuse other sizes
    if (CODE_BITS != `CODE_W) begin : g_bad_code
        $error("code width must match the current-code inputs");
    end
    if (RATE_BITS != `RATE_W) begin : g_bad_rate
        $error("rate width must match the rate carrier");
    end

    step_rate_gen u_rate (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .rif(rif)
    );

    assign rif.run = auto_run & enable;
    assign rif.period = rate_period;

    logic cmd;
    pos_t pos_q, pos_d;
    logic dir_a_q, dir_a_d, dir_b_q, dir_b_d;
    logic [`CODE_W-1:0] code_a_q, code_a_d, code_b_q, code_b_d;
    logic done_q, done_d;
    logic brake_a_q, brake_a_d, brake_b_q, brake_b_d;

    // Polarity table shared by both modes: in wave drive the idle
    // winding's direction is don't-care since its code is zero, so
    // reusing the two-phase pattern keeps one decoder.
    always_comb begin
        // Commands while disabled are dropped, never queued
        cmd = enable & (step_req | rif.tick);
        pos_d = pos_q;
        if (cmd) begin
            pos_d = dir_fwd ? pos_next(pos_q) : pos_prev(pos_q);
        end
        unique case (pos_d)
            POS_0: {dir_a_d, dir_b_d} = 2'b11;
            POS_1: {dir_a_d, dir_b_d} = 2'b01;
            POS_2: {dir_a_d, dir_b_d} = 2'b00;
            POS_3: {dir_a_d, dir_b_d} = 2'b10;
        endcase
        if (!enable) begin
            code_a_d = `CODE_ZERO;
            code_b_d = `CODE_ZERO;
        end else if (mode_t'(mode_two) == MODE_TWO) begin
            code_a_d = `CODE_FULL;
            code_b_d = `CODE_FULL;
        end else if (pos_d == POS_0 || pos_d == POS_2) begin
            code_a_d = `CODE_FULL;
            code_b_d = `CODE_ZERO;
        end else begin
            code_a_d = `CODE_ZERO;
            code_b_d = `CODE_FULL;
        end
        done_d = cmd;
        // Brakes stay low; a zero code de-energises instead
        brake_a_d = 1'b0;
        brake_b_d = 1'b0;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pos_q <= POS_0;
            dir_a_q <= 1'b1;
            dir_b_q <= 1'b1;
            code_a_q <= `CODE_ZERO;
            code_b_q <= `CODE_ZERO;
            done_q <= 1'b0;
            brake_a_q <= 1'b0;
            brake_b_q <= 1'b0;
        end else begin
            pos_q <= pos_d;
            dir_a_q <= dir_a_d;
            dir_b_q <= dir_b_d;
            code_a_q <= code_a_d;
            code_b_q <= code_b_d;
            done_q <= done_d;
            brake_a_q <= brake_a_d;
            brake_b_q <= brake_b_d;
        end
    end

    // Brakes from flops as well, so the pins never glitch
    assign brake_a = brake_a_q;
    assign brake_b = brake_b_q;
    assign dir_a = dir_a_q;
    assign dir_b = dir_b_q;
    assign code_a = code_a_q;
    assign code_b = code_b_q;
    assign step_done = done_q;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_wave_one_on: assert property (
        $past(enable) && !$past(mode_two) |->
        ((code_a_q == `CODE_FULL && code_b_q == `CODE_ZERO &&
          (pos_q == POS_0 || pos_q == POS_2)) ||
         (code_a_q == `CODE_ZERO && code_b_q == `CODE_FULL &&
          (pos_q == POS_1 || pos_q == POS_3))))
        else $error("wave drive winding codes wrong");

    a_forward_order: assert property (
        cmd && dir_fwd |=> pos_q == pos_next($past(pos_q)))
        else $error("forward step did not advance one position");

    a_reverse_order: assert property (
        cmd && !dir_fwd |=> pos_q == pos_prev($past(pos_q)))
        else $error("reverse step did not retreat one position");

    a_wave_handover: assert property (
        cmd && !mode_two && $past(enable) && !$past(mode_two) |=>
        code_a_q != $past(code_a_q) && code_b_q != $past(code_b_q))
        else $error("wave step did not swap windings");

    a_two_full_on: assert property (
        $past(enable) && $past(mode_two) |->
        code_a_q == `CODE_FULL && code_b_q == `CODE_FULL &&
        !brake_a && !brake_b)
        else $error("two-phase codes or brakes wrong");

    a_one_dir_change: assert property (
        cmd |=> (dir_a_q != $past(dir_a_q)) != (dir_b_q != $past(dir_b_q)))
        else $error("step changed zero or two directions");

    // Reset release reloads codes, so the first cycle is left out
    a_hold_between: assert property (
        $past(rst_n) && !cmd && mode_two == $past(mode_two) &&
        enable == $past(enable) |=>
        $stable({dir_a_q, dir_b_q, code_a_q, code_b_q}))
        else $error("outputs moved without a step command");

    a_done_pulse: assert property (
        cmd |=> step_done && pos_q != $past(pos_q))
        else $error("step done not aligned to command");

    a_done_hold: assert property (
        !$past(cmd) |-> !step_done && $stable(pos_q))
        else $error("position moved or done raised without a command");

    a_auto_step: assert property (
        rif.tick && enable |=> step_done)
        else $error("divider tick did not produce a step");

    a_refused_idle: assert property (
        !enable |=> !step_done && $stable(pos_q))
        else $error("command taken while disabled");

    a_disabled_dark: assert property (
        !$past(enable) |-> code_a_q == `CODE_ZERO &&
        code_b_q == `CODE_ZERO)
        else $error("codes not zero while disabled");

    a_two_both_on: assert property (
        cmd && mode_two && $past(enable) && $past(mode_two) |=>
        $stable({code_a_q, code_b_q}))
        else $error("two-phase step dropped a winding");

    a_four_step_cycle: assert property (
        (cmd && dir_fwd)[*4] |=>
        {dir_a_q, dir_b_q} == $past({dir_a_q, dir_b_q}, 4))
        else $error("four forward steps did not return to the start");

    a_half_cycle_flip: assert property (
        (cmd && dir_fwd)[*2] |=>
        {dir_a_q, dir_b_q} == ~$past({dir_a_q, dir_b_q}, 2))
        else $error("two steps did not reverse both windings");
endmodule

// [tb/bridge_model.sv]
// Behavioural bridge channel: current-code threshold and self-restart.
// Assumes fault inputs come from the bench, synchronous to clk_sys.
`timescale 1ns/1ps

module bridge_model #(
    parameter int RESTART = 60
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic dir,
    input wire logic brake,
    input wire logic [3:0] code,
    input wire logic over_cur,
    input wire logic hot,
    input wire logic low_sup,
    output logic on,
    output logic [3:0] level
);
    int wait_q;

    // Restart delay counted from the last cycle over_cur is high, roughly 3 us
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wait_q <= 0;
        end else if (over_cur) begin
            wait_q <= RESTART;
        end else if (wait_q != 0) begin
            wait_q <= wait_q - 1;
        end
    end

    // Lower switches unprotected, so no fault term from them
    // A braked bridge shorts the winding and drives nothing
    assign on = (code != 4'h0) && !brake && wait_q == 0 && !hot && !low_sup;
    // Threshold in sixteenths, bit 3 weighs most; chop timing not modelled
    assign level = code;
endmodule

// [tb/full_step_sequencer_fault_restart_tb.sv]
// Self-checking bench for the full-step sequencer with two bridge models.
// Assumes the sequencer's one-cycle answer and its position table.
`timescale 1ns/1ps
`include "stepper_defines.svh"

module full_step_sequencer_fault_restart_tb;
    import stepper_pkg::*;
    logic clk_sys = 0, rst_n = 0, enable = 0, mode_two = 0;
    logic step_req = 0, dir_fwd = 0, auto_run = 0;
    logic [`RATE_W-1:0] rate_period = `RATE_RESET;
    logic dir_a, brake_a, dir_b, brake_b, step_done, on_a, on_b;
    logic [`CODE_W-1:0] code_a, code_b;
    int miscompares = 0, num_checks = 0, cycles = 0, pos = 0, n;
    logic exp_done = 0, fault_a = 0;

    full_step_sequencer full_step_sequencer_i (.clk_sys(clk_sys),
        .rst_n(rst_n), .enable(enable), .mode_two(mode_two),
        .step_req(step_req), .dir_fwd(dir_fwd), .auto_run(auto_run),
        .rate_period(rate_period), .dir_a(dir_a), .brake_a(brake_a),
        .code_a(code_a), .dir_b(dir_b), .brake_b(brake_b),
        .code_b(code_b), .step_done(step_done));
    bridge_model bridge_model_a (.clk_sys(clk_sys), .rst_n(rst_n),
        .dir(dir_a), .brake(brake_a), .code(code_a), .over_cur(fault_a),
        .hot(1'b0), .low_sup(1'b0), .on(on_a), .level());
    bridge_model bridge_model_b (.clk_sys(clk_sys), .rst_n(rst_n),
        .dir(dir_b), .brake(brake_b), .code(code_b), .over_cur(1'b0),
        .hot(1'b0), .low_sup(1'b0), .on(on_b), .level());

    initial begin
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %0h exp %0h", $time, seen, exp);
        end
    endtask

    task automatic compare_all;
        logic [3:0] ea, eb;
        ea = !enable ? 4'h0 : (mode_two || pos % 2 == 0) ? 4'hF : 4'h0;
        eb = !enable ? 4'h0 : (mode_two || pos % 2 == 1) ? 4'hF : 4'h0;
        check(8'(dir_a), 8'(pos == 0 || pos == 3));
        check(8'(dir_b), 8'(pos <= 1));
        check(8'(code_a), 8'(ea));
        check(8'(code_b), 8'(eb));
        check(8'({brake_a, brake_b}), 8'h00);
        check(8'(step_done), 8'(exp_done));
        if (enable && !mode_two) check(8'(on_a ^ on_b), 8'h01);
    endtask

    // Model advances with the command, design answers one edge later
    task automatic drive(input logic en, m, s, d);
        enable = en;
        mode_two = m;
        step_req = s;
        dir_fwd = d;
        exp_done = en && s;
        if (en && s) pos = (pos + (d ? 1 : 3)) % 4;
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            complete_run;
        end
    end

    initial begin
        void'($urandom(13));
        repeat (16) @(posedge clk_sys);
        #2 rst_n = 1;
        for (int i = 0; i < 400; i++) begin
            @(posedge clk_sys);
            #2 compare_all;
            drive($urandom % 8 != 0, i / 50 % 2 == 1, $urandom % 3 != 0,
                $urandom % 4 != 0);
        end
        $display("test random steps done");
        @(posedge clk_sys);
        #2 compare_all;
        // Mid-run reset returns to the home position
        drive(0, 0, 0, 0);
        rst_n = 0;
        pos = 0;
        exp_done = 0;
        repeat (2) @(posedge clk_sys);
        #2 compare_all;
        rst_n = 1;
        $display("test reset done");
        drive(1, 0, 0, 1);
        rate_period = 16'h0004;
        auto_run = 1;
        n = 0;
        repeat (40) begin
            @(posedge clk_sys);
            #2 if (step_done === 1'b1) n++;
        end
        auto_run = 0;
        repeat (2) begin
            @(posedge clk_sys);
            #2 if (step_done === 1'b1) n++;
        end
        check(8'(n >= 9 && n <= 11), 8'h01);
        pos = (pos + n) % 4;
        compare_all;
        $display("test auto steps done");
        // Overcurrent on A: A drops, B runs on, A restarts unaided
        drive(1, 1, 0, 1);
        @(posedge clk_sys);
        #2 fault_a = 1;
        @(posedge clk_sys);
        #2 fault_a = 0;
        check(8'({on_a, on_b}), 8'h01);
        repeat (59) @(posedge clk_sys);
        #2 check(8'(on_a), 8'h00);
        @(posedge clk_sys);
        #2 check(8'(on_a), 8'h01);
        compare_all;
        $display("test fault restart done");
        complete_run;
    end
endmodule
